// >>> logic/pfra_pkg.sv
`default_nettype none
package pfra_pkg;
  // register byte addresses
  localparam logic [11:0] PFRA_ADDR_ROUTE_MAP = 12'h0D8;
  localparam logic [11:0] PFRA_ADDR_ACCESS = 12'h0DC;
  // route map layout: 3-bit selector per 4-bit field, top bit reserved
  localparam logic [31:0] PFRA_ROUTE_MAP_RESET = 32'h0000_0000;
  localparam logic [31:0] PFRA_ROUTE_MAP_MASK = 32'h7777_7777;
  localparam int PFRA_SEL_W = 3;
  localparam int PFRA_FIELD_W = 4;
  localparam int PFRA_UPPER_BASE = 8;
  // filter compare storage
  localparam int PFRA_NUM_LOC = 16;
  localparam int PFRA_PTR_W = 4;
  localparam logic [3:0] PFRA_PTR_RESET = 4'h0;
  localparam logic [31:0] PFRA_LOC_RESET = 32'h0000_0000;
  localparam logic [31:0] PFRA_RDATA_RESET = 32'h0000_0000;
  // stream path buffering
  localparam int PFRA_DATA_W = 32;
  localparam int PFRA_FIFO_DEPTH = 16;
  localparam logic [2:0] PFRA_PASS_BUFFER = 3'h0;
  typedef logic [PFRA_SEL_W-1:0] pfra_sel_t;
endpackage : pfra_pkg
`default_nettype wire

// >>> logic/pfra_top.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// stream fifo
module pfra_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign o_ready = (count != (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data = mem[rd_idx];
  assign push = i_clk_en && i_valid && o_ready;
  assign pop = i_clk_en && o_valid && i_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_idx] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_idx <= (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pfra_fifo

// ==========================================================
// route map and filter access port
// Function
// - reserved map bits ignore writes and read back as zero.
// - eight 3-bit selectors, locations 15 down to 8, reset zero.
// - when enabled, matched stream data goes to selected buffer.
// - disabled, access port write updates location at write pointer.
// - enabled, access port writes are discarded.
// - access port read returns location at read pointer.
// - disabled, each access port write advances write pointer by one.
// - disabled reads advance read pointer; enabled reads leave it.
// - enabling the filter resets the read pointer to zero.
// - compare uses only mask-one bits; zero mask passes all.
module pfra_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // register port
  input wire logic [11:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  // filter control from the rest of the filter
  input wire logic i_filter_enable_flag,
  input wire logic [31:0] i_compare_mask,
  input wire logic [31:0] i_route_map_lower,
  output logic [pfra_pkg::PFRA_PTR_W-1:0] o_filter_write_pointer,
  output logic [pfra_pkg::PFRA_PTR_W-1:0] o_filter_read_pointer,
  // incoming stream
  input wire logic i_stream_valid,
  output logic o_stream_ready,
  input wire logic [31:0] i_stream_pid,
  input wire logic [pfra_pkg::PFRA_DATA_W-1:0] i_stream_data,
  // routed output
  output logic o_route_valid,
  input wire logic i_route_ready,
  output logic [pfra_pkg::PFRA_SEL_W-1:0] o_route_buffer,
  output logic [pfra_pkg::PFRA_DATA_W-1:0] o_route_data
);
  import pfra_pkg::*;

  logic [31:0] pid_route_map_upper;
  logic [PFRA_NUM_LOC-1:0][31:0] cmp_loc;
  logic [PFRA_PTR_W-1:0] wr_ptr;
  logic [PFRA_PTR_W-1:0] rd_ptr;
  logic enable_q;
  logic map_wr;
  logic acc_wr;
  logic acc_rd;
  logic enable_rise;
  logic [31:0] rd_word;
  logic [PFRA_NUM_LOC-1:0] hit_vec;
  logic hit;
  pfra_sel_t hit_sel;
  logic keep;
  pfra_sel_t push_sel;

  function automatic logic pid_match(input logic [31:0] loc, input logic [31:0] pid,
                                     input logic [31:0] mask);
    return ((loc ^ pid) & mask) == 32'h0000_0000;
  endfunction : pid_match

  function automatic pfra_sel_t sel_of(input int idx, input logic [31:0] lower,
                                       input logic [31:0] upper);
    logic [31:0] word;
    word = (idx >= PFRA_UPPER_BASE) ? upper : lower;
    return word[((idx % PFRA_UPPER_BASE) * PFRA_FIELD_W) +: PFRA_SEL_W];
  endfunction : sel_of

  assign map_wr = i_clk_en && i_reg_wr && (i_reg_addr == PFRA_ADDR_ROUTE_MAP);
  assign acc_wr = i_clk_en && i_reg_wr && (i_reg_addr == PFRA_ADDR_ACCESS);
  assign acc_rd = i_clk_en && i_reg_rd && (i_reg_addr == PFRA_ADDR_ACCESS);
  assign enable_rise = i_filter_enable_flag && !enable_q;
  assign rd_word = cmp_loc[rd_ptr];
  assign o_filter_write_pointer = wr_ptr;
  assign o_filter_read_pointer = rd_ptr;

  // ==========================================================
  // route map register
  // masked store
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pid_route_map_upper <= PFRA_ROUTE_MAP_RESET;
    end else if (map_wr) begin
      pid_route_map_upper <= i_reg_wdata & PFRA_ROUTE_MAP_MASK;
    end
  end

  // ==========================================================
  // compare locations and pointers
  // write only while disabled
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmp_loc <= {PFRA_NUM_LOC{PFRA_LOC_RESET}};
    end else if (acc_wr && !i_filter_enable_flag) begin
      cmp_loc[wr_ptr] <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      enable_q <= 1'b0;
    end else if (i_clk_en) begin
      enable_q <= i_filter_enable_flag;
    end
  end

  // write pointer, held at zero while enabled
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr <= PFRA_PTR_RESET;
    end else if (i_clk_en && i_filter_enable_flag) begin
      wr_ptr <= PFRA_PTR_RESET;
    end else if (acc_wr) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_ptr <= PFRA_PTR_RESET;
    end else if (i_clk_en && enable_rise) begin
      rd_ptr <= PFRA_PTR_RESET;
    end else if (acc_rd && !i_filter_enable_flag) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= PFRA_RDATA_RESET;
    end else if (i_clk_en && i_reg_rd) begin
      unique case (i_reg_addr)
        PFRA_ADDR_ROUTE_MAP: o_reg_rdata <= pid_route_map_upper & PFRA_ROUTE_MAP_MASK;
        PFRA_ADDR_ACCESS: o_reg_rdata <= rd_word;
        default: o_reg_rdata <= PFRA_RDATA_RESET;
      endcase
    end
  end

  // ==========================================================
  // stream matching and routing
  // masked compare, lowest location wins
  always_comb begin
    hit_vec = '0;
    hit_sel = PFRA_PASS_BUFFER;
    for (int k = PFRA_NUM_LOC - 1; k >= 0; k--) begin
      hit_vec[k] = pid_match(cmp_loc[k], i_stream_pid, i_compare_mask);
      if (hit_vec[k]) begin
        hit_sel = sel_of(k, i_route_map_lower, pid_route_map_upper);
      end
    end
  end

  // unmatched data is dropped while enabled; disabled data passes unfiltered
  assign hit = |hit_vec;
  assign keep = !i_filter_enable_flag || hit;
  assign push_sel = i_filter_enable_flag ? hit_sel : PFRA_PASS_BUFFER;

  // back-pressure reaches the source through the fifo ready
  pfra_fifo #(
    .WIDTH(PFRA_SEL_W + PFRA_DATA_W),
    .DEPTH(PFRA_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en),
    .i_valid(i_stream_valid && keep),
    .o_ready(o_stream_ready),
    .i_data({push_sel, i_stream_data}),
    .o_valid(o_route_valid),
    .i_ready(i_route_ready),
    .o_data({o_route_buffer, o_route_data})
  );

  // ==========================================================
  // checks
  a_resvd_read_zero: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && i_reg_rd && i_reg_addr == PFRA_ADDR_ROUTE_MAP)
      |=> (o_reg_rdata & ~PFRA_ROUTE_MAP_MASK) == 32'h0000_0000)
    else $error("reserved route map bits read nonzero");
  a_map_write_keep: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    map_wr |=> pid_route_map_upper == ($past(i_reg_wdata) & PFRA_ROUTE_MAP_MASK))
    else $error("route map write not stored");
  a_acc_write_upd: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (acc_wr && !i_filter_enable_flag) |=> cmp_loc[$past(wr_ptr)] == $past(i_reg_wdata))
    else $error("access write did not update location");
  a_acc_write_drop: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (acc_wr && i_filter_enable_flag) |=> $stable(cmp_loc))
    else $error("access write changed locations while enabled");
  a_acc_read_data: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    acc_rd |=> o_reg_rdata == $past(rd_word))
    else $error("access read returned wrong location");
  a_wr_ptr_step: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (acc_wr && !i_filter_enable_flag) |=> wr_ptr == $past(wr_ptr) + 4'h1)
    else $error("write pointer did not advance");
  a_rd_ptr_hold: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (acc_rd && i_filter_enable_flag && enable_q) |=> $stable(rd_ptr))
    else $error("read pointer moved while enabled");
  a_rd_ptr_clear: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && enable_rise) |=> rd_ptr == 4'h0)
    else $error("read pointer not cleared on enable");
  a_mask_zero_pass: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_compare_mask == 32'h0000_0000) |-> hit_vec == 16'hFFFF)
    else $error("zero mask blocked a pid");
  a_lowest_route: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_filter_enable_flag && hit_vec[0]) |-> push_sel == i_route_map_lower[2:0])
    else $error("lowest match did not choose route");
endmodule : pfra_top
`default_nettype wire

// >>> sim/pfra_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// host microcontroller on the register port
module pfra_host_model (
  // clock
  input wire logic i_clk,
  // register port
  output logic [11:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [31:0] o_wdata,
  input wire logic [31:0] i_rdata
);
  initial begin
    o_addr = 12'h000;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 32'h0000_0000;
  end

  // released data is inverted so a stale word is never mistaken for fresh
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask : reg_wr

  // read data is registered, so it is taken one edge after the strobe
  task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
    d = i_rdata;
  endtask : reg_rd
endmodule : pfra_host_model
`default_nettype wire

// >>> sim/pid_filter_route_access_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// bench top
module pid_filter_route_access_tb_top;
  import pfra_pkg::*;
  logic clk, rst_n, ce, en, sv, rr, wr, rd, sready, rvalid;
  logic [11:0] addr;
  logic [31:0] wd, rdata, mask, lower, pid, sdata, rdat;
  logic [3:0] wp, rp;
  logic [2:0] rbuf;
  int n_mismatch, compares, cyc;

  pfra_top uut (.i_clk(clk), .i_reset_n(rst_n), .i_clk_en(ce), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdata),
    .i_filter_enable_flag(en), .i_compare_mask(mask), .i_route_map_lower(lower),
    .o_filter_write_pointer(wp), .o_filter_read_pointer(rp), .i_stream_valid(sv),
    .o_stream_ready(sready), .i_stream_pid(pid), .i_stream_data(sdata),
    .o_route_valid(rvalid), .i_route_ready(rr), .o_route_buffer(rbuf), .o_route_data(rdat));
  pfra_host_model host (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wd),
    .i_rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // checking
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host.reg_rd(a, d);
    chk(d, exp, "register read");
  endtask : rd_chk

  task automatic send(input logic [31:0] p, input logic [31:0] d);
    @(posedge clk);
    #1;
    pid = p;
    sdata = d;
    sv = 1'b1;
    while (sready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    sv = 1'b0;
    pid = ~p;
    sdata = ~d;
  endtask : send

  task automatic pop_chk(input logic [2:0] b, input logic [31:0] d);
    int k;
    k = 0;
    // one edge between drains so ready is never lowered and raised in one step
    @(posedge clk);
    #1;
    while (rvalid !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({29'h0, rbuf}, {29'h0, b}, "route buffer");
    chk(rdat, d, "route data");
    rr = 1'b1;
    @(posedge clk);
    #1;
    rr = 1'b0;
  endtask : pop_chk

  task automatic end_of_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ==========================================================
  // scenarios
  task automatic t_reset_map();
    rd_chk(PFRA_ADDR_ROUTE_MAP, 32'h0000_0000);
    rd_chk(PFRA_ADDR_ACCESS, 32'h0000_0000);
    chk({28'h0, rp}, 32'h0000_0001, "read pointer");
    host.reg_wr(PFRA_ADDR_ROUTE_MAP, 32'hFFFF_FFFF);
    rd_chk(PFRA_ADDR_ROUTE_MAP, 32'h7777_7777);
    host.reg_wr(PFRA_ADDR_ROUTE_MAP, 32'h7654_3210);
    rd_chk(PFRA_ADDR_ROUTE_MAP, 32'h7654_3210);
  endtask : t_reset_map

  // read pointer starts at 1 after the read in the reset scenario
  task automatic t_access();
    for (int i = 0; i < 16; i++) begin
      host.reg_wr(PFRA_ADDR_ACCESS, 32'h0000_0100 + i);
      chk({28'h0, wp}, (i + 1) % 16, "write pointer");
    end
    for (int i = 0; i < 16; i++) rd_chk(PFRA_ADDR_ACCESS, 32'h0000_0100 + (i + 1) % 16);
    chk({28'h0, rp}, 32'h0000_0001, "read pointer wrap");
  endtask : t_access

  task automatic t_enable();
    en = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({28'h0, rp}, 32'h0000_0000, "read pointer cleared");
    host.reg_wr(PFRA_ADDR_ACCESS, 32'hDEAD_BEEF);
    chk({28'h0, wp}, 32'h0000_0000, "write pointer held");
    rd_chk(PFRA_ADDR_ACCESS, 32'h0000_0100);
    chk({28'h0, rp}, 32'h0000_0000, "read pointer still");
  endtask : t_enable

  task automatic t_route();
    mask = 32'hFFFF_FFFF;
    send(32'h0000_0109, 32'hA1A1_0001);
    pop_chk(3'h1, 32'hA1A1_0001);
    send(32'h0000_0200, 32'hA1A1_0002);
    send(32'h0000_010F, 32'hA1A1_0003);
    pop_chk(3'h7, 32'hA1A1_0003);
    mask = 32'h0000_00F0;
    send(32'h0000_010A, 32'hA1A1_0004);
    pop_chk(3'h5, 32'hA1A1_0004);
    mask = 32'h0000_0000;
    send(32'h0000_0999, 32'hA1A1_0005);
    pop_chk(3'h5, 32'hA1A1_0005);
    en = 1'b0;
    send(32'h0000_0109, 32'hA1A1_0006);
    pop_chk(PFRA_PASS_BUFFER, 32'hA1A1_0006);
  endtask : t_route

  // drain side stalls while the fifo fills to refusal
  task automatic t_fifo();
    for (int i = 0; i < PFRA_FIFO_DEPTH; i++) send(i, 32'hB000_0000 + i);
    chk({31'h0, sready}, 32'h0000_0000, "fifo full");
    for (int i = 0; i < PFRA_FIFO_DEPTH; i++) pop_chk(3'h0, 32'hB000_0000 + i);
    chk({31'h0, rvalid}, 32'h0000_0000, "fifo empty");
  endtask : t_fifo

  // a low clock enable must freeze pointers, read data and the stream path alike
  task automatic t_freeze();
    ce = 1'b0;
    host.reg_wr(PFRA_ADDR_ACCESS, 32'h5555_AAAA);
    rd_chk(PFRA_ADDR_ACCESS, 32'h0000_0100);
    chk({28'h0, wp}, 32'h0000_0000, "write pointer frozen");
    chk({28'h0, rp}, 32'h0000_0000, "read pointer frozen");
    send(32'h0000_0109, 32'hC0C0_0001);
    chk({31'h0, rvalid}, 32'h0000_0000, "stream frozen");
    ce = 1'b1;
    host.reg_wr(PFRA_ADDR_ACCESS, 32'h5555_AAAA);
    chk({28'h0, wp}, 32'h0000_0001, "write pointer resumed");
    rd_chk(PFRA_ADDR_ACCESS, 32'h5555_AAAA);
    chk({28'h0, rp}, 32'h0000_0001, "read pointer resumed");
  endtask : t_freeze

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    en = 1'b0;
    sv = 1'b0;
    rr = 1'b0;
    mask = 32'h0000_0000;
    lower = 32'h0000_0005;
    pid = 32'h0000_0000;
    sdata = 32'h0000_0000;
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset_map();
    t_access();
    t_enable();
    t_route();
    t_fifo();
    t_freeze();
    end_of_test();
  end
endmodule : pid_filter_route_access_tb_top
`default_nettype wire
